// ===== bench/light_result_register_bank_tb.sv
// Self-checking bench for the light result register bank
`timescale 1ns/1ps
`default_nettype none
module light_result_register_bank_tb;
  logic clk, rst, conv_done_first, conv_done_second;
  logic [3:0] scale_in_first, scale_in_second;
  logic [19:0] value_in_first, value_in_second;
  logic ptr_load, byte_take, stop_seen, burst_en, tx_valid_q;
  logic [7:0] ptr_value, ptr_q, tx_byte_q;
  int failures = 0;
  int total_checks = 0;
  // Slots: 0 first live, 1 second live, 2 first buffered, 3 second buffered
  logic [3:0] m_sc[4];
  logic [19:0] m_va[4];
  logic [3:0] m_ta[4];

  light_result_register_bank #(.PTR_W(8)) i_light_result_register_bank (
    .clk(clk), .rst(rst),
    .conv_done_first(conv_done_first), .scale_in_first(scale_in_first),
    .value_in_first(value_in_first), .conv_done_second(conv_done_second),
    .scale_in_second(scale_in_second), .value_in_second(value_in_second),
    .ptr_load(ptr_load), .ptr_value(ptr_value), .byte_take(byte_take),
    .stop_seen(stop_seen), .burst_en(burst_en),
    .tx_byte_q(tx_byte_q), .tx_valid_q(tx_valid_q), .ptr_q(ptr_q));

  read_host #(.PTR_W(8)) i_read_host (
    .clk(clk), .ptr_load(ptr_load), .ptr_value(ptr_value), .byte_take(byte_take),
    .stop_seen(stop_seen), .burst_en(burst_en),
    .tx_byte_q(tx_byte_q), .tx_valid_q(tx_valid_q));

  // ==========================================
  // Clock, 20 ns period from time zero
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================
  // Reference model
  function automatic logic [3:0] chk(input logic [3:0] e, input logic [19:0] r,
                                     input logic [3:0] c);
    chk[0] = ^{e, r, c};
    chk[1] = c[1] ^ c[3] ^ e[1] ^ e[3] ^ r[1] ^ r[3] ^ r[5] ^ r[7] ^ r[9] ^ r[11]
             ^ r[13] ^ r[15] ^ r[17] ^ r[19];
    chk[2] = c[3] ^ r[3] ^ r[7] ^ r[11] ^ r[15] ^ r[19] ^ e[3];
    chk[3] = r[3] ^ r[11] ^ r[19];
  endfunction : chk

  function automatic logic [15:0] exp_word(input int r);
    int s;
    s = r / 2;
    if (r > 7) return 16'h0000;
    if (r % 2 == 0) return {m_sc[s], m_va[s][19:8]};
    return {m_va[s][7:0], m_ta[s], chk(m_sc[s], m_va[s], m_ta[s])};
  endfunction : exp_word

  task model_clear;
    for (int i = 0; i < 4; i++) begin
      m_sc[i] = 4'h0;
      m_va[i] = 20'h00000;
      m_ta[i] = 4'h0;
    end
  endtask : model_clear

  // ==========================================
  // Compare tasks
  task cmp_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word

  task cmp_ptr(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_ptr

  // ==========================================
  // Stimulus helpers
  // Second channel gets inverted fields so the two channels never match by accident
  task conv(input logic e0, input logic e1, input logic [3:0] s, input logic [19:0] v);
    @(negedge clk);
    conv_done_first = e0;
    conv_done_second = e1;
    scale_in_first = s;
    value_in_first = v;
    scale_in_second = ~s;
    value_in_second = ~v;
    for (int c = 0; c < 2; c++) begin
      if (c == 0 ? e0 : e1) begin
        m_sc[c + 2] = m_sc[c];
        m_va[c + 2] = m_va[c];
        m_ta[c + 2] = m_ta[c];
        m_sc[c] = c == 0 ? s : ~s;
        m_va[c] = c == 0 ? v : ~v;
        m_ta[c] = m_ta[c] + 4'h1;
      end
    end
  endtask : conv

  task conv_end;
    @(negedge clk);
    conv_done_first = 1'b0;
    conv_done_second = 1'b0;
    value_in_first = ~value_in_first;
    value_in_second = ~value_in_second;
  endtask : conv_end

  task check_regs(input int first, input int n, input int gap);
    logic [15:0] w;
    i_read_host.load(8'(first));
    cmp_ptr(ptr_q, 8'(first));
    for (int i = 0; i < n; i++) begin
      i_read_host.read_word(gap, w);
      cmp_word(w, exp_word(burst_en ? first + i : first));
      cmp_ptr(ptr_q, 8'(burst_en ? first + i + 1 : first));
    end
    i_read_host.stop();
    cmp_ptr(ptr_q, 8'(first));
  endtask : check_regs

  // ==========================================
  // Scenarios
  task scn_reset_values;
    i_read_host.set_burst(1'b1);
    check_regs(0, 9, 0);
  endtask : scn_reset_values

  task scn_single_reads;
    i_read_host.set_burst(1'b0);
    conv(1'b1, 1'b0, 4'h9, 20'hA5C3B);
    conv_end();
    check_regs(0, 2, 3);
    check_regs(1, 1, 0);
  endtask : scn_single_reads

  task scn_both_channels;
    i_read_host.set_burst(1'b1);
    conv(1'b1, 1'b1, 4'hE, 20'h5A3C4);
    conv(1'b1, 1'b0, 4'h3, 20'h80808);
    conv(1'b0, 1'b1, 4'hB, 20'hF00F1);
    conv_end();
    check_regs(0, 8, 0);
  endtask : scn_both_channels

  task scn_tally_wrap;
    for (int i = 0; i < 17; i++) begin
      conv(1'b0, 1'b1, 4'(i), 20'h12345 + 20'(i * 4099));
    end
    conv_end();
    check_regs(2, 2, 1);
    check_regs(6, 2, 0);
  endtask : scn_tally_wrap

  task scn_mid_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    model_clear();
    check_regs(0, 8, 0);
  endtask : scn_mid_reset

  // ==========================================
  // Verdict, main sequence and watchdog
  task tally_and_finish;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    rst = 1'b1;
    conv_done_first = 1'b0;
    conv_done_second = 1'b0;
    scale_in_first = 4'h0;
    scale_in_second = 4'h0;
    value_in_first = 20'h00000;
    value_in_second = 20'h00000;
    model_clear();
    repeat (20) @(negedge clk);
    rst = 1'b0;
    scn_reset_values();
    scn_single_reads();
    scn_both_channels();
    scn_tally_wrap();
    scn_mid_reset();
    tally_and_finish();
  end

  // The run needs under two hundred cycles; this limit of 5000 cycles leaves wide margin
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
endmodule : light_result_register_bank_tb
`default_nettype wire

// ===== bench/read_host.sv
// Serial host model that points at, reads and releases the result registers
`timescale 1ns/1ps
`default_nettype none
module read_host #(
  parameter int PTR_W = 8
) (
  // Clock
  input wire logic clk,
  // Requests to the bank
  output logic ptr_load,
  output logic [PTR_W-1:0] ptr_value,
  output logic byte_take,
  output logic stop_seen,
  output logic burst_en,
  // Answers from the bank
  input wire logic [7:0] tx_byte_q,
  input wire logic tx_valid_q
);
  // ==========================================
  // Idle state; the host never writes results
  initial begin
    ptr_load = 1'b0;
    ptr_value = '0;
    byte_take = 1'b0;
    stop_seen = 1'b0;
    burst_en = 1'b0;
  end

  task set_burst(input logic b);
    @(negedge clk);
    burst_en = b;
  endtask : set_burst

  // Released pointer lines show the inverse so a stale value cannot pass
  task load(input logic [PTR_W-1:0] p);
    @(negedge clk);
    ptr_load = 1'b1;
    ptr_value = p;
    @(negedge clk);
    ptr_load = 1'b0;
    ptr_value = ~p;
  endtask : load

  // Two bytes per register, high first; gap idles between them for a slow host
  task read_word(input int gap, output logic [15:0] w);
    @(negedge clk);
    byte_take = 1'b1;
    @(negedge clk);
    w[15:8] = tx_valid_q ? tx_byte_q : 8'hXX;
    if (gap > 0) begin
      byte_take = 1'b0;
      repeat (gap) @(negedge clk);
      byte_take = 1'b1;
    end
    @(negedge clk);
    w[7:0] = tx_valid_q ? tx_byte_q : 8'hXX;
    byte_take = 1'b0;
  endtask : read_word

  task stop;
    @(negedge clk);
    stop_seen = 1'b1;
    @(negedge clk);
    stop_seen = 1'b0;
  endtask : stop
endmodule : read_host
`default_nettype wire

// ===== common/light_pkg.sv
// Constants shared by the light result register bank and its helpers
`default_nettype none
package light_pkg;

  // ==========================================
  // Field widths
  localparam int SCALE_W = 4;
  localparam int VALUE_W = 20;
  localparam int UPPER_W = 12;
  localparam int LOWER_W = 8;
  localparam int TALLY_W = 4;
  localparam int CHECK_W = 4;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int PTR_W_DEFAULT = 8;

  // ==========================================
  // Register offsets (register index on the serial bus)
  localparam logic [7:0] OFS_FIRST_RESULT_HIGH = 8'h00;
  localparam logic [7:0] OFS_FIRST_RESULT_LOW = 8'h01;
  localparam logic [7:0] OFS_SECOND_RESULT_HIGH = 8'h02;
  localparam logic [7:0] OFS_SECOND_RESULT_LOW = 8'h03;
  localparam logic [7:0] OFS_FIRST_BUFFERED_HIGH = 8'h04;
  localparam logic [7:0] OFS_FIRST_BUFFERED_LOW = 8'h05;
  localparam logic [7:0] OFS_SECOND_BUFFERED_HIGH = 8'h06;
  localparam logic [7:0] OFS_SECOND_BUFFERED_LOW = 8'h07;

  // ==========================================
  // Field positions inside a 16-bit word
  localparam int POS_SCALE = 12;
  localparam int POS_UPPER = 0;
  localparam int POS_LOWER = 8;
  localparam int POS_TALLY = 4;
  localparam int POS_CHECK = 0;
  localparam int UPPER_SHIFT = 8;

  // ==========================================
  // Reset and unmapped values
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0] UNMAPPED_BYTE = 8'h00;

endpackage : light_pkg
`default_nettype wire

// ===== common/sample_if.sv
// Live and buffered sample fields of one channel
`timescale 1ns/1ps
`default_nettype none
interface sample_if;
  logic [3:0] scale;
  logic [19:0] value;
  logic [3:0] tally;
  logic [3:0] check;
  logic [3:0] buf_scale;
  logic [19:0] buf_value;
  logic [3:0] buf_tally;
  logic [3:0] buf_check;

  modport producer(
    output scale, value, tally, check,
    output buf_scale, buf_value, buf_tally, buf_check
  );
  modport consumer(
    input scale, value, tally, check,
    input buf_scale, buf_value, buf_tally, buf_check
  );
endinterface : sample_if
`default_nettype wire

// ===== hdl/channel_store.sv
// Live result and one buffered copy for one channel
`timescale 1ns/1ps
`default_nettype none
module channel_store (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Conversion results
  input wire logic conv_done,
  input wire logic [3:0] scale_in,
  input wire logic [19:0] value_in,
  // Stored fields
  sample_if.producer smp
);
  // ==========================================
  // Sample storage
  logic [3:0] scale_q, scale_d, tally_q, tally_d, bscale_q, bscale_d;
  logic [3:0] btally_q, btally_d, bcheck_q, bcheck_d, live_check;
  logic [19:0] value_q, value_d, bvalue_q, bvalue_d;

  check_bits u_check (
    .scale(scale_q),
    .value(value_q),
    .tally(tally_q),
    .check(live_check)
  );

  always_comb begin
    scale_d = scale_q;
    value_d = value_q;
    tally_d = tally_q;
    bscale_d = bscale_q;
    bvalue_d = bvalue_q;
    btally_d = btally_q;
    bcheck_d = bcheck_q;
    if (conv_done) begin
      // Whole sample moves in one edge so fields of two samples never mix
      bscale_d = scale_q; // RULE11 RULE17
      bvalue_d = value_q; // RULE11
      btally_d = tally_q; // RULE11
      bcheck_d = live_check; // RULE11
      scale_d = scale_in; // RULE17
      value_d = value_in; // RULE17
      tally_d = tally_q + 4'h1; // RULE5
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      scale_q <= 4'h0; // RULE13
      value_q <= 20'h00000;
      tally_q <= 4'h0;
      bscale_q <= 4'h0;
      bvalue_q <= 20'h00000;
      btally_q <= 4'h0;
      bcheck_q <= 4'h0;
    end else begin
      scale_q <= scale_d;
      value_q <= value_d;
      tally_q <= tally_d;
      bscale_q <= bscale_d;
      bvalue_q <= bvalue_d;
      btally_q <= btally_d;
      bcheck_q <= bcheck_d;
    end
  end

  assign smp.scale = scale_q;
  assign smp.value = value_q;
  assign smp.tally = tally_q;
  assign smp.check = live_check;
  assign smp.buf_scale = bscale_q;
  assign smp.buf_value = bvalue_q;
  assign smp.buf_tally = btally_q;
  assign smp.buf_check = bcheck_q;

  // ==========================================
  // Checks
  a_tally_wraps: assert property (@(posedge clk) disable iff (rst) // RULE5
    conv_done |=> tally_q == 4'($past(tally_q) + 4'h1))
    else $error("sample tally did not advance by one");
  a_tally_hold: assert property (@(posedge clk) disable iff (rst) // RULE5
    !conv_done |=> tally_q == $past(tally_q))
    else $error("sample tally moved without a conversion");
  a_live_update: assert property (@(posedge clk) disable iff (rst) // RULE17
    conv_done |=> scale_q == $past(scale_in) && value_q == $past(value_in))
    else $error("live fields not taken in one edge");
  a_check_top: assert property (@(posedge clk) disable iff (rst) // RULE9
    conv_done |=> live_check[3] ==
      ($past(value_in[3]) ^ $past(value_in[11]) ^ $past(value_in[19])))
    else $error("check bit 3 wrong after conversion");
  a_check_two: assert property (@(posedge clk) disable iff (rst) // RULE8
    conv_done |=> live_check[2] == ($past(value_in[3]) ^ $past(value_in[7])
      ^ $past(value_in[11]) ^ $past(value_in[15]) ^ $past(value_in[19])
      ^ $past(scale_in[3]) ^ tally_q[3]))
    else $error("check bit 2 wrong after conversion");
  a_check_parity: assert property (@(posedge clk) disable iff (rst) // RULE6
    conv_done |=> live_check[0] == ^{$past(scale_in), $past(value_in), tally_q})
    else $error("check bit 0 is not the parity of all fields");
  a_check_one: assert property (@(posedge clk) disable iff (rst) // RULE7
    conv_done |=> live_check[1] == (tally_q[1] ^ tally_q[3] ^ $past(scale_in[1])
      ^ $past(scale_in[3]) ^ ^($past(value_in) & 20'hAAAAA)))
    else $error("check bit 1 wrong after conversion");
  a_buffer_copy: assert property (@(posedge clk) disable iff (rst) // RULE11
    conv_done |=> bvalue_q == $past(value_q) && bcheck_q == $past(live_check))
    else $error("buffered copy is not the previous live sample");
  a_reset_clear: assert property (@(posedge clk) // RULE13
    rst |=> value_q == 20'h00000 && bvalue_q == 20'h00000 && tally_q == 4'h0)
    else $error("result fields not cleared by reset");
endmodule : channel_store
`default_nettype wire

// ===== hdl/check_bits.sv
// Four check bits over scale code, 20-bit value and sample tally
`timescale 1ns/1ps
`default_nettype none
module check_bits (
  // Sample fields
  input wire logic [3:0] scale,
  input wire logic [19:0] value,
  input wire logic [3:0] tally,
  // Check result
  output logic [3:0] check
);
  always_comb begin
    check[0] = ^{scale, value, tally}; // RULE6
    check[1] = tally[1] ^ tally[3] ^ value[1] ^ value[3] ^ value[5] ^ value[7] ^ value[9]
             ^ value[11] ^ value[13] ^ value[15] ^ value[17] ^ value[19]
             ^ scale[1] ^ scale[3]; // RULE7
    check[2] = tally[3] ^ value[3] ^ value[7] ^ value[11] ^ value[15] ^ value[19]
             ^ scale[3]; // RULE8
    check[3] = value[3] ^ value[11] ^ value[19]; // RULE9
  end
endmodule : check_bits
`default_nettype wire

// ===== hdl/light_result_register_bank.sv
// Read-only result register bank of a two-channel light sensor
//
// Behaviour
// RULE1 - First channel scale code sits in bits 15-12 of register 0.
// RULE2 - First channel upper 12 value bits sit in bits 11-0 of register 0.
// RULE3 - First channel lower 8 value bits sit in bits 15-8 of register 1.
// RULE4 - The 20-bit value is upper part shifted left eight plus lower part.
// RULE5 - A 4-bit sample tally in bits 7-4 advances per conversion and wraps.
// RULE6 - Check bit 0 is the parity of scale, value and tally bits.
// RULE7 - Check bit 1 covers tally 1,3, odd value bits, scale 1,3.
// RULE8 - Check bit 2 covers tally 3, value 3,7,11,15,19, scale 3.
// RULE9 - Check bit 3 covers value bits 3, 11 and 19.
// RULE10 - Second channel uses registers 2 and 3 with identical layout.
// RULE11 - Buffered first channel sample appears at registers 4 and 5.
// RULE12 - Buffered second channel scale and upper bits appear at register 6.
// RULE13 - All result fields are read-only and clear to zero on reset.
// RULE14 - Burst mode advances pointer per two bytes; stop restores original pointer.
// RULE15 - Each register goes out high byte first, then low byte.
// RULE16 - Buffered second channel lower, tally, check appear at register 7.
// RULE17 - High and low fields of a channel update together per conversion.
`timescale 1ns/1ps
`default_nettype none
module light_result_register_bank #(
  parameter int PTR_W = light_pkg::PTR_W_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // First channel conversion results
  input wire logic conv_done_first,
  input wire logic [3:0] scale_in_first,
  input wire logic [19:0] value_in_first,
  // Second channel conversion results
  input wire logic conv_done_second,
  input wire logic [3:0] scale_in_second,
  input wire logic [19:0] value_in_second,
  // Serial engine requests
  input wire logic ptr_load,
  input wire logic [PTR_W-1:0] ptr_value,
  input wire logic byte_take,
  input wire logic stop_seen,
  input wire logic burst_en,
  // Serial engine answers
  output logic [7:0] tx_byte_q,
  output logic tx_valid_q,
  output logic [PTR_W-1:0] ptr_q
);
  // ==========================================
  // Elaboration checks
  // Offsets decode as 8-bit codes; a wider pointer would alias registers above FFh
  if (PTR_W < 4 || PTR_W > 8) begin : g_bad_width
    $error("PTR_W must be 4 to 8 bits");
  end

  // ==========================================
  // Channel storage
  sample_if first_smp ();
  sample_if second_smp ();

  channel_store u_first (
    .clk(clk),
    .rst(rst),
    .conv_done(conv_done_first),
    .scale_in(scale_in_first),
    .value_in(value_in_first),
    .smp(first_smp.producer)
  );

  channel_store u_second (
    .clk(clk),
    .rst(rst),
    .conv_done(conv_done_second),
    .scale_in(scale_in_second),
    .value_in(value_in_second),
    .smp(second_smp.producer)
  ); // RULE10

  // ==========================================
  // Word assembly
  function automatic logic [15:0] high_word(input logic [3:0] s, input logic [19:0] v);
    high_word = light_pkg::RESULT_RESET;
    high_word[light_pkg::POS_SCALE +: light_pkg::SCALE_W] = s; // RULE1
    high_word[light_pkg::POS_UPPER +: light_pkg::UPPER_W] =
      v[light_pkg::UPPER_SHIFT +: light_pkg::UPPER_W]; // RULE2 RULE4
  endfunction : high_word

  function automatic logic [15:0] low_word(input logic [19:0] v, input logic [3:0] t,
                                           input logic [3:0] c);
    low_word = light_pkg::RESULT_RESET;
    low_word[light_pkg::POS_LOWER +: light_pkg::LOWER_W] = v[light_pkg::LOWER_W-1:0]; // RULE3 RULE4
    low_word[light_pkg::POS_TALLY +: light_pkg::TALLY_W] = t; // RULE5
    low_word[light_pkg::POS_CHECK +: light_pkg::CHECK_W] = c; // RULE6
  endfunction : low_word

  logic [15:0] word_sel;
  logic mapped;

  always_comb begin
    word_sel = light_pkg::RESULT_RESET;
    mapped = 1'b1;
    case (8'(ptr_q))
      light_pkg::OFS_FIRST_RESULT_HIGH:
        word_sel = high_word(first_smp.scale, first_smp.value); // RULE1 RULE2
      light_pkg::OFS_FIRST_RESULT_LOW:
        word_sel = low_word(first_smp.value, first_smp.tally, first_smp.check); // RULE3
      light_pkg::OFS_SECOND_RESULT_HIGH:
        word_sel = high_word(second_smp.scale, second_smp.value); // RULE10
      light_pkg::OFS_SECOND_RESULT_LOW:
        word_sel = low_word(second_smp.value, second_smp.tally, second_smp.check); // RULE10
      light_pkg::OFS_FIRST_BUFFERED_HIGH:
        word_sel = high_word(first_smp.buf_scale, first_smp.buf_value); // RULE11
      light_pkg::OFS_FIRST_BUFFERED_LOW:
        word_sel = low_word(first_smp.buf_value, first_smp.buf_tally,
                            first_smp.buf_check); // RULE11
      light_pkg::OFS_SECOND_BUFFERED_HIGH:
        word_sel = high_word(second_smp.buf_scale, second_smp.buf_value); // RULE12
      light_pkg::OFS_SECOND_BUFFERED_LOW:
        word_sel = low_word(second_smp.buf_value, second_smp.buf_tally,
                            second_smp.buf_check); // RULE16
      default: begin
        // Other registers live outside this bank
        mapped = 1'b0;
      end
    endcase
  end

  // ==========================================
  // Read pointer and byte sequencing
  // Writes from the serial engine never reach the result fields: no write path exists.
  logic [PTR_W-1:0] ptr_d, base_q, base_d;
  logic low_next_q, low_next_d;
  logic [7:0] tx_byte_d;
  logic tx_valid_d;

  always_comb begin
    ptr_d = ptr_q;
    base_d = base_q;
    low_next_d = low_next_q;
    tx_byte_d = tx_byte_q;
    tx_valid_d = 1'b0;
    if (ptr_load) begin
      ptr_d = ptr_value;
      base_d = ptr_value;
      low_next_d = 1'b0;
    end else if (stop_seen) begin
      ptr_d = base_q; // RULE14
      low_next_d = 1'b0;
    end else if (byte_take) begin
      tx_valid_d = 1'b1;
      if (!mapped) begin
        tx_byte_d = light_pkg::UNMAPPED_BYTE;
      end else if (low_next_q) begin
        tx_byte_d = word_sel[7:0]; // RULE15
      end else begin
        tx_byte_d = word_sel[15:8]; // RULE15
      end
      low_next_d = !low_next_q;
      if (low_next_q && burst_en) begin
        // Base is kept so a stop can undo every increment of the burst
        ptr_d = ptr_q + PTR_W'(1); // RULE14
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_q <= '0;
      base_q <= '0;
      low_next_q <= 1'b0;
      tx_byte_q <= 8'h00;
      tx_valid_q <= 1'b0;
    end else begin
      ptr_q <= ptr_d;
      base_q <= base_d;
      low_next_q <= low_next_d;
      tx_byte_q <= tx_byte_d;
      tx_valid_q <= tx_valid_d;
    end
  end

  // ==========================================
  // Checks
  // Last loaded pointer, kept apart from base_q so that a broken restore cannot hide
  logic [PTR_W-1:0] loaded_q, loaded_d;
  logic take_high, take_low;

  assign take_high = byte_take && !ptr_load && !stop_seen && !low_next_q;
  assign take_low = byte_take && !ptr_load && !stop_seen && low_next_q;

  always_comb begin
    loaded_d = loaded_q;
    if (ptr_load) begin
      loaded_d = ptr_value;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      loaded_q <= '0;
    end else begin
      loaded_q <= loaded_d;
    end
  end

  a_reset_outputs: assert property (@(posedge clk) // RULE13
    rst |=> ptr_q == '0 && !tx_valid_q && tx_byte_q == 8'h00)
    else $error("read port not cleared by reset");

  a_load_pointer: assert property (@(posedge clk) disable iff (rst) // RULE14
    ptr_load |=> ptr_q == $past(ptr_value) && !low_next_q)
    else $error("pointer load not taken");

  a_burst_advance: assert property (@(posedge clk) disable iff (rst) // RULE14
    take_low && burst_en |=> ptr_q == PTR_W'($past(ptr_q) + PTR_W'(1)))
    else $error("burst did not advance pointer after low byte");

  a_no_burst_hold: assert property (@(posedge clk) disable iff (rst) // RULE14
    !ptr_load && !stop_seen && !burst_en |=> ptr_q == $past(ptr_q))
    else $error("pointer moved with burst off");

  a_stop_restore: assert property (@(posedge clk) disable iff (rst) // RULE14
    stop_seen && !ptr_load |=> ptr_q == loaded_q)
    else $error("stop did not restore original pointer");

  a_stop_high: assert property (@(posedge clk) disable iff (rst) // RULE15
    stop_seen && !ptr_load |=> !low_next_q)
    else $error("stop did not return to the high byte");

  a_refused_silent: assert property (@(posedge clk) disable iff (rst) // RULE15
    ptr_load || stop_seen || !byte_take |=> !tx_valid_q)
    else $error("byte answered without a valid take");

  a_high_first: assert property (@(posedge clk) disable iff (rst) // RULE15
    take_high && mapped |=> tx_valid_q && tx_byte_q == $past(word_sel[15:8]))
    else $error("high byte not sent first");

  a_low_second: assert property (@(posedge clk) disable iff (rst) // RULE15
    take_low && mapped |=> tx_valid_q && tx_byte_q == $past(word_sel[7:0]))
    else $error("low byte not sent second");

  a_first_layout: assert property (@(posedge clk) disable iff (rst) // RULE1
    take_high && ptr_q == PTR_W'(light_pkg::OFS_FIRST_RESULT_HIGH)
      |=> tx_byte_q == {$past(first_smp.scale), $past(first_smp.value[19:16])})
    else $error("register 0 high byte layout wrong");

  a_first_upper: assert property (@(posedge clk) disable iff (rst) // RULE2 RULE4
    take_low && ptr_q == PTR_W'(light_pkg::OFS_FIRST_RESULT_HIGH)
      |=> tx_byte_q == $past(first_smp.value[15:8]))
    else $error("register 0 low byte layout wrong");

  a_first_lower: assert property (@(posedge clk) disable iff (rst) // RULE3 RULE4
    take_high && ptr_q == PTR_W'(light_pkg::OFS_FIRST_RESULT_LOW)
      |=> tx_byte_q == $past(first_smp.value[7:0]))
    else $error("register 1 high byte layout wrong");

  a_first_tally: assert property (@(posedge clk) disable iff (rst) // RULE5 RULE6
    take_low && ptr_q == PTR_W'(light_pkg::OFS_FIRST_RESULT_LOW)
      |=> tx_byte_q == {$past(first_smp.tally), $past(first_smp.check)})
    else $error("register 1 low byte layout wrong");

  a_second_layout: assert property (@(posedge clk) disable iff (rst) // RULE10
    take_high && ptr_q == PTR_W'(light_pkg::OFS_SECOND_RESULT_HIGH)
      |=> tx_byte_q == {$past(second_smp.scale), $past(second_smp.value[19:16])})
    else $error("register 2 high byte layout wrong");

  a_second_upper: assert property (@(posedge clk) disable iff (rst) // RULE10
    take_low && ptr_q == PTR_W'(light_pkg::OFS_SECOND_RESULT_HIGH)
      |=> tx_byte_q == $past(second_smp.value[15:8]))
    else $error("register 2 low byte layout wrong");

  a_second_lower: assert property (@(posedge clk) disable iff (rst) // RULE10
    take_high && ptr_q == PTR_W'(light_pkg::OFS_SECOND_RESULT_LOW)
      |=> tx_byte_q == $past(second_smp.value[7:0]))
    else $error("register 3 high byte layout wrong");

  a_second_tally: assert property (@(posedge clk) disable iff (rst) // RULE10
    take_low && ptr_q == PTR_W'(light_pkg::OFS_SECOND_RESULT_LOW)
      |=> tx_byte_q == {$past(second_smp.tally), $past(second_smp.check)})
    else $error("register 3 low byte layout wrong");

  a_first_buffered: assert property (@(posedge clk) disable iff (rst) // RULE11
    take_high && ptr_q == PTR_W'(light_pkg::OFS_FIRST_BUFFERED_HIGH)
      |=> tx_byte_q == {$past(first_smp.buf_scale), $past(first_smp.buf_value[19:16])})
    else $error("register 4 high byte layout wrong");

  a_buffered_upper: assert property (@(posedge clk) disable iff (rst) // RULE11
    take_low && ptr_q == PTR_W'(light_pkg::OFS_FIRST_BUFFERED_HIGH)
      |=> tx_byte_q == $past(first_smp.buf_value[15:8]))
    else $error("register 4 low byte layout wrong");

  a_buffered_tally: assert property (@(posedge clk) disable iff (rst) // RULE11
    take_low && ptr_q == PTR_W'(light_pkg::OFS_FIRST_BUFFERED_LOW)
      |=> tx_byte_q == {$past(first_smp.buf_tally), $past(first_smp.buf_check)})
    else $error("register 5 low byte layout wrong");

  a_second_buffered: assert property (@(posedge clk) disable iff (rst) // RULE12
    take_high && ptr_q == PTR_W'(light_pkg::OFS_SECOND_BUFFERED_HIGH)
      |=> tx_byte_q == {$past(second_smp.buf_scale), $past(second_smp.buf_value[19:16])})
    else $error("register 6 high byte layout wrong");

  a_buffer_lower: assert property (@(posedge clk) disable iff (rst) // RULE16
    take_high && ptr_q == PTR_W'(light_pkg::OFS_SECOND_BUFFERED_LOW)
      |=> tx_byte_q == $past(second_smp.buf_value[7:0]))
    else $error("register 7 high byte layout wrong");

  a_buffer_layout: assert property (@(posedge clk) disable iff (rst) // RULE16
    take_low && ptr_q == PTR_W'(light_pkg::OFS_SECOND_BUFFERED_LOW)
      |=> tx_byte_q == {$past(second_smp.buf_tally), $past(second_smp.buf_check)})
    else $error("register 7 low byte layout wrong");
endmodule : light_result_register_bank
`default_nettype wire
